// ===== rtl/adc_ctrl_consts.vh
// Constants for the converter control block: register offsets, field
// positions, reset values and conversion timing counts.
// Included by the converter control design files by bare name.
`ifndef ADC_CTRL_CONSTS_VH
`define ADC_CTRL_CONSTS_VH
// Register byte offsets on APB
`define OFF_INPUT_SELECT 12'h000
`define OFF_CONTROL_A 12'h004
`define OFF_CONTROL_B 12'h008
`define OFF_RESULT_LOW 12'h00C
`define OFF_RESULT_HIGH 12'h010
// input_select_register fields
`define SEL_REF_HI 7
`define SEL_REF_LO 6
`define SEL_LEFT_ALIGN 5
`define SEL_INPUT_HI 4
`define SEL_INPUT_LO 0
// converter_control_a fields
`define CA_ENABLE 7
`define CA_START 6
`define CA_AUTO_TRIG 5
`define CA_DONE_FLAG 4
`define CA_IRQ_EN 3
`define CA_PRESC_HI 2
`define CA_PRESC_LO 0
// converter_control_b fields
`define CB_TRIG_HI 2
`define CB_TRIG_LO 0
// Trigger source code that selects the done flag (free running)
`define TRIG_FREE_RUN 3'h0
// Reset values
`define RST_INPUT_SELECT 8'h00
`define RST_CONTROL_A 8'h00
`define RST_CONTROL_B 8'h00
// Conversion length in converter clock cycles
`define CONV_CYCLES_NORMAL 5'd13
`define CONV_CYCLES_FIRST 5'd25
`endif

// ===== rtl/adc_prescaler.v
// Converter clock prescaler: divides the CPU clock into a one-cycle
// enable pulse by 2^(select+1); select 0 gives divide by 2.
// Assumes one CPU clock; the caller holds it in reset via i_clear.
`timescale 1ns/10ps
module adc_prescaler #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Control
  input wire i_clear,
  input wire [2:0] i_select,
  // Converter clock enable
  output wire o_tick
);
  reg [WIDTH-1:0] count_q;
  wire [WIDTH-1:0] limit;

  // Terminal count for the chosen ratio
  assign limit = ({{(WIDTH-1){1'b0}}, 1'b1} << i_select) << 1;
  assign o_tick = (count_q == limit - {{(WIDTH-1){1'b0}}, 1'b1}) && !i_clear;

  // Free counter, restarted on clear so the first tick has a fixed delay
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_q <= {WIDTH{1'b0}};
    end else if (i_clear || o_tick) begin
      count_q <= {WIDTH{1'b0}};
    end else begin
      count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule // adc_prescaler

// ===== rtl/adc_conversion_control.v
// Converter control: APB register bank, start logic, conversion timer,
// result alignment and two-byte read lock for a 10-bit SAR converter.
// Assumes the analog core presents its code on I_SAR_CODE at completion.
// Assumes every input, trigger levels included, is synchronous to I_CLOCK.
// Assumes the register bank is reached over APB with no wait states.
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "adc_ctrl_consts.vh"
module adc_conversion_control #(
  parameter PRESC_WIDTH = 8
) (
  // Clock and reset
  input wire I_CLOCK,
  input wire I_RST_N,
  // APB slave
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire [11:0] I_PADDR,
  input wire [31:0] I_PWDATA,
  output wire [31:0] O_PRDATA,
  output wire O_PREADY,
  output wire O_PSLVERR,
  // Trigger sources, codes 1 to 7 of the trigger select field
  input wire [7:1] I_TRIGGER,
  // Analog core
  input wire [9:0] I_SAR_CODE,
  output reg O_CORE_POWER,
  output reg O_CORE_SAMPLE,
  output reg [4:0] O_CORE_INPUT,
  output reg [1:0] O_CORE_REF,
  // Conversion complete interrupt
  output wire O_DONE_IRQ
);
  // Sequencer states: idle, waiting for the converter edge, converting
  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_CONV = 2'd2;

  // Register and sequencer state
  reg [7:0] sel_q;
  reg en_q;
  reg start_q;
  reg auto_q;
  reg done_q;
  reg irq_en_q;
  reg [2:0] presc_q;
  reg [2:0] trig_sel_q;
  reg [9:0] result_q;
  reg lock_q;
  reg first_q;
  reg [1:0] state_q;
  reg [4:0] cyc_q;
  reg trig_prev_q;
  reg align_q;
  reg [7:0] rdata;

  // Decodes and internal strobes
  wire tick;
  wire presc_clear;
  wire wr;
  wire rd;
  wire trig_level;
  wire trig_edge;
  wire hw_trigger;
  wire sw_start;
  wire [4:0] conv_len;
  wire finish;
  wire [15:0] aligned;
  wire done_clear;
  wire wr_ctrl_a;
  wire rd_low;
  wire rd_high;
  wire free_run;
  wire conv_begin;
  wire sel_update;

  // Bus strobes; zero wait states
  assign wr = I_PSEL && I_PENABLE && I_PWRITE;
  assign rd = I_PSEL && I_PENABLE && !I_PWRITE;
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = 1'b0;
  assign O_DONE_IRQ = done_q && irq_en_q;

  // Register-specific strobes, decoded once and shared by the processes below
  assign wr_ctrl_a = wr && (I_PADDR == `OFF_CONTROL_A);
  assign rd_low = rd && (I_PADDR == `OFF_RESULT_LOW);
  assign rd_high = rd && (I_PADDR == `OFF_RESULT_HIGH);

  // Trigger level; code 0 is the done flag itself
  assign trig_level = (trig_sel_q == `TRIG_FREE_RUN) ? 1'b0 : I_TRIGGER[trig_sel_q];
  assign trig_edge = trig_level && !trig_prev_q;
  assign conv_len = first_q ? `CONV_CYCLES_FIRST : `CONV_CYCLES_NORMAL;
  assign finish = (state_q == ST_CONV) && tick && (cyc_q == conv_len - 5'd1);
  // Hardware start only when idle; edges in a conversion are dropped
  assign hw_trigger = en_q && auto_q && (state_q == ST_IDLE) && trig_edge;

  // The written enable bit qualifies a start, so one write may enable and start;
  // a write that clears enable never starts a conversion
  assign sw_start = wr_ctrl_a && I_PWDATA[`CA_START] && I_PWDATA[`CA_ENABLE];
  assign presc_clear = !en_q || hw_trigger;
  assign done_clear = wr_ctrl_a && I_PWDATA[`CA_DONE_FLAG];

  // Done flag as trigger source restarts at every completion
  assign free_run = auto_q && (trig_sel_q == `TRIG_FREE_RUN);
  // A conversion begins on the first tick after a start, or at once when free running
  assign conv_begin = ((state_q == ST_WAIT) && tick) || (finish && free_run);
  // Selections follow software while enabled, except during a conversion; they reopen in the
  // completion cycle so a mid-conversion change lands before the next one samples
  assign sel_update = en_q && ((state_q != ST_CONV) || finish);

  // Result placed in the two bytes per the alignment
  assign aligned = align_q ? {result_q, 6'h00} : {6'h00, result_q};

  // Converter clock divider; restarted on disable and on a trigger for a fixed start delay
  adc_prescaler #(
    .WIDTH(PRESC_WIDTH)
  ) u_presc (
    .i_clk(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_clear(presc_clear),
    .i_select(presc_q),
    .o_tick(tick)
  );

  // Previous trigger sample for edge detection
  // Resets low, the idle level of a trigger, so leaving reset makes no false edge
  always @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= trig_level;
    end
  end

  // Software registers
  // Start and done live with the sequencer and the flag logic, not here
  always @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sel_q <= `RST_INPUT_SELECT;
      en_q <= 1'b0;
      auto_q <= 1'b0;
      irq_en_q <= 1'b0;
      presc_q <= 3'h0;
      trig_sel_q <= 3'h0;
      align_q <= 1'b0;
    end else if (wr) begin
      if (I_PADDR == `OFF_INPUT_SELECT) begin
        sel_q <= I_PWDATA[7:0];
        align_q <= I_PWDATA[`SEL_LEFT_ALIGN];
      end else if (I_PADDR == `OFF_CONTROL_A) begin
        en_q <= I_PWDATA[`CA_ENABLE];
        auto_q <= I_PWDATA[`CA_AUTO_TRIG];
        irq_en_q <= I_PWDATA[`CA_IRQ_EN];
        presc_q <= I_PWDATA[`CA_PRESC_HI:`CA_PRESC_LO];
      end else if (I_PADDR == `OFF_CONTROL_B) begin
        trig_sel_q <= I_PWDATA[`CB_TRIG_HI:`CB_TRIG_LO];
      end
    end
  end

  // Conversion sequencer: wait for converter edge, then count cycles
  // A disable aborts any conversion and rearms the long first conversion
  always @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_q <= ST_IDLE;
      cyc_q <= 5'd0;
      start_q <= 1'b0;
      first_q <= 1'b1;
    end else if (!en_q && !sw_start) begin
      state_q <= ST_IDLE;
      cyc_q <= 5'd0;
      start_q <= 1'b0;
      first_q <= 1'b1; // Next enable gets the long first conversion
    end else begin
      case (state_q)
        ST_IDLE: begin
          // A start write and a trigger edge are only heard while idle
          if (sw_start || hw_trigger) begin
            state_q <= ST_WAIT;
            start_q <= 1'b1;
          end
        end
        ST_WAIT: begin
          // Hold until the converter clock edge after the start
          if (tick) begin
            state_q <= ST_CONV;
            cyc_q <= 5'd0;
          end
        end
        ST_CONV: begin
          // Count converter cycles; the last tick completes the conversion
          if (finish) begin
            first_q <= 1'b0;
            cyc_q <= 5'd0;
            if (free_run) begin
              state_q <= ST_CONV;
            end else begin
              state_q <= ST_IDLE;
              start_q <= 1'b0;
            end
          end else if (tick) begin
            cyc_q <= cyc_q + 5'd1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Done flag: write one clears; completion wins over clear
  // Set and clear in one cycle leave the flag set, so no completion goes unseen
  always @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      done_q <= 1'b0;
    end else if (finish) begin
      done_q <= 1'b1;
    end else if (done_clear) begin
      done_q <= 1'b0;
    end
  end

  // Result and read lock; a finish that meets the lock is dropped
  // Both bytes freeze after a low read, but a finish in the low-read cycle still loads, so the high read can belong to a newer code
  always @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      result_q <= 10'h000;
      lock_q <= 1'b0;
    end else begin
      if (finish && !lock_q) begin
        result_q <= I_SAR_CODE;
      end
      if (rd_high) begin
        lock_q <= 1'b0;
      end else if (rd_low) begin
        lock_q <= 1'b1;
      end
    end
  end

  // Selections follow software while enabled, and are frozen during a conversion until its completion cycle
  // The sample pulse marks the first converter cycle of every conversion
  always @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_CORE_POWER <= 1'b0;
      O_CORE_INPUT <= 5'h00;
      O_CORE_REF <= 2'h0;
      O_CORE_SAMPLE <= 1'b0;
    end else begin
      O_CORE_POWER <= en_q;
      O_CORE_SAMPLE <= en_q && conv_begin;
      if (sel_update) begin
        O_CORE_INPUT <= sel_q[`SEL_INPUT_HI:`SEL_INPUT_LO];
        O_CORE_REF <= sel_q[`SEL_REF_HI:`SEL_REF_LO];
      end
    end
  end

  // Read mux; unmapped offsets read zero
  // Registers are eight bits wide; the upper bus bits always read zero
  always @* begin
    if (I_PADDR == `OFF_INPUT_SELECT) begin
      rdata = sel_q;
    end else if (I_PADDR == `OFF_CONTROL_A) begin
      rdata = {en_q, start_q, auto_q, done_q, irq_en_q, presc_q};
    end else if (I_PADDR == `OFF_CONTROL_B) begin
      rdata = {5'h00, trig_sel_q};
    end else if (I_PADDR == `OFF_RESULT_LOW) begin
      rdata = aligned[7:0];
    end else if (I_PADDR == `OFF_RESULT_HIGH) begin
      rdata = aligned[15:8];
    end else begin
      rdata = 8'h00;
    end
  end
  assign O_PRDATA = {24'h000000, rdata};
endmodule // adc_conversion_control

// ===== tb/adc_conversion_control_properties.sv
// Port checker for the converter control block.
// Assumes one clock domain and a zero-wait APB slave.
`timescale 1ns/10ps
`include "adc_ctrl_consts.vh"
module adc_ctrl_checker (
  // Clock, reset and APB
  input wire I_CLOCK,
  input wire I_RST_N,
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire [11:0] I_PADDR,
  input wire [31:0] I_PWDATA,
  input wire [31:0] O_PRDATA,
  input wire O_PREADY,
  input wire O_PSLVERR,
  // Analog core and interrupt
  input wire O_CORE_POWER,
  input wire O_CORE_SAMPLE,
  input wire [4:0] O_CORE_INPUT,
  input wire [1:0] O_CORE_REF,
  input wire O_DONE_IRQ
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);
  // Access-phase decodes
  wire rd = I_PSEL & I_PENABLE & !I_PWRITE;
  wire wr_a = I_PSEL & I_PENABLE & I_PWRITE & (I_PADDR == `OFF_CONTROL_A);
  AST_READY: assert property (I_PSEL & I_PENABLE |-> O_PREADY)
    else $error("pready low in access");
  AST_NO_ERR: assert property (!O_PSLVERR) else $error("pslverr raised");
  AST_RD_UPPER: assert property (rd |-> O_PRDATA[31:8] == 24'h000000)
    else $error("upper read bits set");
  AST_UNMAPPED: assert property (rd && I_PADDR == 12'h020 |-> O_PRDATA == 32'h00000000)
    else $error("unmapped read not zero");
  AST_IRQ_OFF: assert property (wr_a && !I_PWDATA[3] |=> !O_DONE_IRQ)
    else $error("irq stays up after mask");
  AST_POWER_ON: assert property (wr_a && I_PWDATA[7] |-> ##[1:2] O_CORE_POWER)
    else $error("core not powered");
  AST_POWER_OFF: assert property (wr_a && !I_PWDATA[7] |-> ##[1:2] !O_CORE_POWER)
    else $error("core not powered down");
  AST_SAMPLE_PULSE: assert property (O_CORE_SAMPLE |=> !O_CORE_SAMPLE)
    else $error("sample pulse too long");
  AST_SAMPLE_POWER: assert property (O_CORE_SAMPLE |-> O_CORE_POWER)
    else $error("sample while unpowered");
  AST_SEL_FROZEN: assert property (O_CORE_SAMPLE |=> $stable({O_CORE_REF, O_CORE_INPUT})[*8])
    else $error("selection moved in conversion");
  AST_CTRL_READ: assert property (rd && I_PADDR == `OFF_CONTROL_A
    |-> O_PRDATA[7] == O_CORE_POWER) else $error("enable readback differs");
endmodule // adc_ctrl_checker

// ===== tb/test_adc_conversion_control.sv
// Self-checking bench for the converter control block.
// Assumes a divide-by-2 prescale select and a zero-wait APB slave.
`timescale 1ns/10ps
`include "adc_ctrl_consts.vh"
module test_adc_conversion_control;
  reg I_CLOCK, I_RST_N, I_PSEL, I_PENABLE, I_PWRITE;
  reg [11:0] I_PADDR;
  reg [31:0] I_PWDATA;
  reg [7:1] I_TRIGGER;
  reg [9:0] I_SAR_CODE;
  wire [31:0] O_PRDATA;
  wire O_PREADY, O_PSLVERR, O_CORE_POWER, O_CORE_SAMPLE, O_DONE_IRQ;
  wire [4:0] O_CORE_INPUT;
  wire [1:0] O_CORE_REF;
  integer errors, check_count, seed, i;
  reg [31:0] rd;
  reg [9:0] code_a, code_b;
  reg [7:0] sel, sel2;
  adc_conversion_control #(.PRESC_WIDTH(8)) uut (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N),
    .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
    .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .I_TRIGGER(I_TRIGGER), .I_SAR_CODE(I_SAR_CODE), .O_CORE_POWER(O_CORE_POWER),
    .O_CORE_SAMPLE(O_CORE_SAMPLE), .O_CORE_INPUT(O_CORE_INPUT), .O_CORE_REF(O_CORE_REF),
    .O_DONE_IRQ(O_DONE_IRQ));
  // Free-running 100 MHz clock
  always #5 I_CLOCK = ~I_CLOCK;
  // Expected result bytes for a code and alignment
  function [31:0] exp_lo(input [9:0] c, input l);
    exp_lo = l ? {24'h000000, c[1:0], 6'h00} : {24'h000000, c[7:0]};
  endfunction
  function [31:0] exp_hi(input [9:0] c, input l);
    exp_hi = l ? {24'h000000, c[9:2]} : {24'h000000, 6'h00, c[9:8]};
  endfunction
  task close_out;
    begin
      $display("Checks %0d, mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // One APB transfer; an idle edge first so strobes never change twice in a step
  task apb(input [11:0] a, input w, input [31:0] d);
    integer n;
    begin
      @(posedge I_CLOCK);
      I_PSEL <= 1'b1;
      I_PENABLE <= 1'b0;
      I_PWRITE <= w;
      I_PADDR <= a;
      I_PWDATA <= d;
      @(posedge I_CLOCK);
      I_PENABLE <= 1'b1;
      n = 0;
      @(posedge I_CLOCK);
      while (O_PREADY !== 1'b1 && n < 20) begin
        @(posedge I_CLOCK);
        n = n + 1;
      end
      if (n >= 20) begin
        errors = errors + 1;
        close_out;
      end
      rd = O_PRDATA;
      I_PSEL <= 1'b0;
      I_PENABLE <= 1'b0;
    end
  endtask
  // Poll the start bit until the conversion is over, bounded
  task wait_idle;
    integer n;
    begin
      n = 0;
      rd = 32'h00000040;
      while (rd[6] !== 1'b0 && n < 60) begin
        apb(`OFF_CONTROL_A, 1'b0, 32'h0);
        n = n + 1;
      end
      if (n >= 60) begin
        errors = errors + 1;
        close_out;
      end
    end
  endtask
  // Main sequence
  initial begin
    I_CLOCK = 0; I_RST_N = 0; I_PSEL = 0; I_PENABLE = 0; I_PWRITE = 0; I_PADDR = 0;
    I_PWDATA = 0; I_TRIGGER = 0; I_SAR_CODE = 0; errors = 0; check_count = 0;
    seed = 32'hA075;
    repeat (4) @(posedge I_CLOCK);
    I_RST_N <= 1'b1;
    apb(`OFF_CONTROL_B, 1'b0, 32'h0);
    chk(rd, {24'h000000, `RST_CONTROL_B});
    apb(12'h020, 1'b1, 32'hFF);
    apb(12'h020, 1'b0, 32'h0);
    chk(rd, 32'h0);
    $display("Reset and unmapped test done");
    // Random single conversions, both alignments, selection change mid-run
    for (i = 0; i < 4; i = i + 1) begin
      code_a = $random(seed);
      sel = $random(seed);
      sel[5] = i[0];
      sel2 = sel ^ 8'h1F;
      apb(`OFF_INPUT_SELECT, 1'b1, {24'h000000, sel});
      I_SAR_CODE <= code_a;
      apb(`OFF_CONTROL_A, 1'b1, 32'hD8);
      apb(`OFF_CONTROL_A, 1'b0, 32'h0);
      chk(rd[6], 1'b1);
      apb(`OFF_INPUT_SELECT, 1'b1, {24'h000000, sel2});
      chk({O_CORE_REF, O_CORE_INPUT}, {sel[7:6], sel[4:0]});
      wait_idle;
      chk(rd[4], 1'b1);
      chk(O_DONE_IRQ, 1'b1);
      chk({O_CORE_REF, O_CORE_INPUT}, {sel2[7:6], sel2[4:0]});
      apb(`OFF_RESULT_LOW, 1'b0, 32'h0);
      chk(rd, exp_lo(code_a, sel[5]));
      apb(`OFF_RESULT_HIGH, 1'b0, 32'h0);
      chk(rd, exp_hi(code_a, sel[5]));
    end
    $display("Single conversion test done");
    // Low byte read locks; a finished conversion is lost until high is read
    apb(`OFF_RESULT_LOW, 1'b0, 32'h0);
    code_b = $random(seed);
    I_SAR_CODE <= code_b;
    apb(`OFF_CONTROL_A, 1'b1, 32'hD8);
    wait_idle;
    chk(rd[4], 1'b1);
    apb(`OFF_RESULT_HIGH, 1'b0, 32'h0);
    chk(rd, exp_hi(code_a, sel[5]));
    apb(`OFF_CONTROL_A, 1'b1, 32'hD8);
    wait_idle;
    apb(`OFF_RESULT_LOW, 1'b0, 32'h0);
    chk(rd, exp_lo(code_b, sel[5]));
    apb(`OFF_RESULT_HIGH, 1'b0, 32'h0);
    $display("Read lock test done");
    // Auto trigger: edge starts, edge in conversion and held level do not
    apb(`OFF_CONTROL_B, 1'b1, 32'h1);
    apb(`OFF_CONTROL_A, 1'b1, 32'hB0);
    I_TRIGGER[1] <= 1'b1;
    apb(`OFF_CONTROL_A, 1'b0, 32'h0);
    chk(rd[6], 1'b1);
    I_TRIGGER[1] <= 1'b0;
    @(posedge I_CLOCK);
    I_TRIGGER[1] <= 1'b1;
    wait_idle;
    repeat (40) @(posedge I_CLOCK);
    apb(`OFF_CONTROL_A, 1'b0, 32'h0);
    chk(rd[6], 1'b0);
    apb(`OFF_CONTROL_A, 1'b1, 32'hF0);
    apb(`OFF_CONTROL_A, 1'b0, 32'h0);
    chk(rd[6], 1'b1);
    wait_idle;
    I_TRIGGER[1] <= 1'b0;
    $display("Auto trigger test done");
    // Free running on the done flag, started by one start write
    apb(`OFF_CONTROL_B, 1'b1, {29'h0000000, `TRIG_FREE_RUN});
    code_b = $random(seed);
    I_SAR_CODE <= code_b;
    apb(`OFF_CONTROL_A, 1'b1, 32'hF0);
    repeat (80) @(posedge I_CLOCK);
    apb(`OFF_CONTROL_A, 1'b0, 32'h0);
    chk(rd[7:4], 4'hF);
    apb(`OFF_RESULT_LOW, 1'b0, 32'h0);
    chk(rd, exp_lo(code_b, sel[5]));
    apb(`OFF_CONTROL_A, 1'b1, 32'h0);
    apb(`OFF_CONTROL_A, 1'b0, 32'h0);
    chk(O_CORE_POWER, 1'b0);
    $display("Free running test done");
    close_out;
  end
endmodule // test_adc_conversion_control
bind adc_conversion_control adc_ctrl_checker chk_i (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N),
  .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
  .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
  .O_CORE_POWER(O_CORE_POWER), .O_CORE_SAMPLE(O_CORE_SAMPLE), .O_CORE_INPUT(O_CORE_INPUT),
  .O_CORE_REF(O_CORE_REF), .O_DONE_IRQ(O_DONE_IRQ));
